// ---- hdl/fwd_ctrl_cfg.svh ----
`ifndef FWD_CTRL_CFG_SVH
`define FWD_CTRL_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MAC_FIRST 8'h68
`define OFS_MAC_LAST  8'h6D
`define OFS_UCAST     8'h83
`define OFS_MCAST     8'h84
`define OFS_VID       8'h85
`define OFS_IPMC      8'h86
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define POS_EN        5
`define POS_SELF      6
`define POS_DRV       6
`define POS_MCAST_BIT 40
`define RST_MAP       5'h00
`define RST_EN        1'h0
`define RST_DRV       2'h1
`define RST_MAC       8'h00
`endif

// ---- hdl/fwd_ctrl_pkg.sv ----
package fwd_ctrl_pkg;
  typedef enum logic [2:0] {
    cls_known,
    cls_ucast,
    cls_mcast,
    cls_ipmcast,
    cls_vid
  } class_type;

  typedef struct packed {
    logic       en;
    logic [4:0] map;
  } class_cfg_type;
endpackage : fwd_ctrl_pkg

// ---- hdl/fwd_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fwd_cfg_if;
  import fwd_ctrl_pkg::*;
  class_cfg_type ucast;
  class_cfg_type mcast;
  class_cfg_type vid;
  class_cfg_type ipmc;

  modport source (
    output ucast,
    output mcast,
    output vid,
    output ipmc
  );
  modport sink (
    input ucast,
    input mcast,
    input vid,
    input ipmc
  );
endinterface : fwd_cfg_if
`default_nettype wire

// ---- hdl/unknown_class_resolver.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwd_ctrl_cfg.svh"
module unknown_class_resolver (
  fwd_cfg_if.sink                  cfg,
  input  wire logic [47:0]         da_i,
  input  wire logic                da_hit_i,
  input  wire logic                vid_hit_i,
  input  wire logic                ip_mcast_i,
  output fwd_ctrl_pkg::class_type  cls_o,
  output logic                     override_o,
  output logic                     drop_o,
  output logic [3:0]               ports_o
);
  import fwd_ctrl_pkg::*;

  // ----------------------------------------
  // Port map decode
  // ----------------------------------------
  // Bit 0 is ignored, so the reserved 00001 also filters
  function automatic logic [3:0] map_ports(input logic [4:0] m);
    map_ports = m[4:1];
  endfunction : map_ports

  function automatic logic map_filter(input logic [4:0] m);
    map_filter = (map_ports(m) == 4'h0);
  endfunction : map_filter

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  // A VLAN miss outranks a destination miss
  wire logic da_mcast = da_i[`POS_MCAST_BIT];
  wire class_type cls_w =
    !vid_hit_i ? cls_vid :
    da_hit_i   ? cls_known :
    ip_mcast_i ? cls_ipmcast :
    da_mcast   ? cls_mcast :
                 cls_ucast;

  wire class_cfg_type sel_w =
    (cls_w == cls_vid)     ? cfg.vid :
    (cls_w == cls_ipmcast) ? cfg.ipmc :
    (cls_w == cls_mcast)   ? cfg.mcast :
    (cls_w == cls_ucast)   ? cfg.ucast :
                             '0;

  assign cls_o      = cls_w;
  assign override_o = sel_w.en;
  assign drop_o     = sel_w.en && map_filter(sel_w.map);
  assign ports_o    = sel_w.en ? map_ports(sel_w.map) : 4'h0;
endmodule : unknown_class_resolver
`default_nettype wire

// ---- hdl/unknown_dest_forward_control.sv ----
// Behaviour
// - Unknown unicast enable on: unicast misses follow their port map
// - Unknown unicast map of zero filters those frames
// - Port maps ignore bit 0; bits 4:1 pick ports 4..1, all ones floods
// - Unknown multicast map covers non-IP multicast misses only
// - Unknown multicast map of zero filters; 00001 is reserved
// - Unknown VID enable on: VLAN misses follow their port map
// - Unknown VID map of zero filters those frames
// - Unknown IP multicast enable on: IP multicast misses follow map
// - Unknown IP multicast map of zero filters those frames
// - Self filter on: frames to the own MAC address are dropped
// - Self filter acts at egress against the six own-address registers
// - Self filter off after reset: own-address frames pass
`timescale 1ns/1ps
`default_nettype none
`include "fwd_ctrl_cfg.svh"
module unknown_dest_forward_control #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [DATA_W-1:0]        rd_data_o,
  input  wire logic                frm_valid_i,
  input  wire logic [47:0]         frm_da_i,
  input  wire logic                frm_da_hit_i,
  input  wire logic                frm_vid_hit_i,
  input  wire logic                frm_ip_mcast_i,
  output logic                     dec_valid_o,
  output fwd_ctrl_pkg::class_type  dec_class_o,
  output logic                     dec_override_o,
  output logic                     dec_drop_o,
  output logic [3:0]               dec_ports_o,
  input  wire logic                egr_valid_i,
  input  wire logic [47:0]         egr_da_i,
  output logic                     egr_done_o,
  output logic                     egr_drop_o,
  output logic [1:0]               drive_sel_o
);
  import fwd_ctrl_pkg::*;

  if (ADDR_W != 8 || DATA_W != 8) begin : g_check
    $error("Register port must be 8 bit address and 8 bit data");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic hit_ucast = (addr_i == `OFS_UCAST);
  wire logic hit_mcast = (addr_i == `OFS_MCAST);
  wire logic hit_vid   = (addr_i == `OFS_VID);
  wire logic hit_ipmc  = (addr_i == `OFS_IPMC);
  wire logic hit_mac   = (addr_i >= `OFS_MAC_FIRST) &&
                         (addr_i <= `OFS_MAC_LAST);
  wire logic [2:0] mac_idx = 3'(addr_i - `OFS_MAC_FIRST);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  class_cfg_type ucast_q;
  class_cfg_type mcast_q;
  class_cfg_type vid_q;
  class_cfg_type ipmc_q;
  logic          self_q;
  logic [1:0]    drv_q;
  logic [7:0]    mac_q [0:5];
  logic [47:0]   mac_w;

  wire class_cfg_type wr_cfg = {wr_data_i[`POS_EN], wr_data_i[4:0]};
  localparam class_cfg_type CFG_RST = {`RST_EN, `RST_MAP};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ucast_q <= CFG_RST;
      mcast_q <= CFG_RST;
      vid_q   <= CFG_RST;
      ipmc_q  <= CFG_RST;
      drv_q   <= `RST_DRV;
    end else if (wr_i) begin
      if (hit_ucast) begin
        ucast_q <= wr_cfg;
      end
      if (hit_mcast) begin
        mcast_q <= wr_cfg;
        drv_q   <= wr_data_i[`POS_DRV +: 2];
      end
      if (hit_vid) begin
        vid_q <= wr_cfg;
      end
      if (hit_ipmc) begin
        ipmc_q <= wr_cfg;
      end
    end
  end

  // Self filter stays off until software turns it on
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      self_q <= `RST_EN;
    end else if (wr_i && hit_ipmc) begin
      self_q <= wr_data_i[`POS_SELF];
    end
  end

  // Own address, first register holds the top byte
  for (genvar i = 0; i < 6; i++) begin : g_mac
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        mac_q[i] <= `RST_MAC;
      end else if (wr_i && hit_mac && mac_idx == 3'(i)) begin
        mac_q[i] <= wr_data_i;
      end
    end
    assign mac_w[47-8*i -: 8] = mac_q[i];
  end

  assign drive_sel_o = drv_q;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Reserved bits and unmapped offsets read as zero
  wire logic [7:0] rd_mux =
    hit_ucast ? {2'h0, ucast_q} :
    hit_mcast ? {drv_q, mcast_q} :
    hit_vid   ? {2'h0, vid_q} :
    hit_ipmc  ? {1'h0, self_q, ipmc_q} :
    hit_mac   ? mac_q[mac_idx] :
                8'h00;

  // Data stand for the one cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Unknown destination decision
  // ----------------------------------------
  fwd_cfg_if cfg_bus ();
  assign cfg_bus.ucast = ucast_q;
  assign cfg_bus.mcast = mcast_q;
  assign cfg_bus.vid   = vid_q;
  assign cfg_bus.ipmc  = ipmc_q;

  class_type  res_cls;
  logic       res_ovr;
  logic       res_drop;
  logic [3:0] res_ports;

  unknown_class_resolver u_resolver (
    .cfg        (cfg_bus.sink),
    .da_i       (frm_da_i),
    .da_hit_i   (frm_da_hit_i),
    .vid_hit_i  (frm_vid_hit_i),
    .ip_mcast_i (frm_ip_mcast_i),
    .cls_o      (res_cls),
    .override_o (res_ovr),
    .drop_o     (res_drop),
    .ports_o    (res_ports)
  );

  // One cycle of latency keeps the fabric path off the table outputs
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dec_valid_o    <= 1'h0;
      dec_class_o    <= cls_known;
      dec_override_o <= 1'h0;
      dec_drop_o     <= 1'h0;
      dec_ports_o    <= 4'h0;
    end else begin
      dec_valid_o <= frm_valid_i;
      if (frm_valid_i) begin
        dec_class_o    <= res_cls;
        dec_override_o <= res_ovr;
        dec_drop_o     <= res_drop;
        dec_ports_o    <= res_ports;
      end
    end
  end

  // ----------------------------------------
  // Egress self-address filter
  // ----------------------------------------
  // All 48 address bits are compared, multicast bit included: both kinds match alike
  wire logic self_hit = self_q && (egr_da_i == mac_w);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      egr_done_o <= 1'h0;
      egr_drop_o <= 1'h0;
    end else begin
      egr_done_o <= egr_valid_i;
      egr_drop_o <= egr_valid_i && self_hit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  wire logic da_miss = frm_vid_hit_i && !frm_da_hit_i;
  wire logic is_uc   = da_miss && !frm_ip_mcast_i &&
                       !frm_da_i[`POS_MCAST_BIT];
  wire logic is_mc   = da_miss && !frm_ip_mcast_i &&
                       frm_da_i[`POS_MCAST_BIT];
  wire logic is_ipmc = da_miss && frm_ip_mcast_i;

  sequence s_self_on;
    wr_i && hit_ipmc && wr_data_i[`POS_SELF];
  endsequence

  sequence s_own_frame;
    egr_valid_i && (egr_da_i == mac_w);
  endsequence

  sequence s_ucast_cfg;
    wr_i && hit_ucast && wr_data_i[`POS_EN];
  endsequence

  sequence s_ucast_frame;
    frm_valid_i && is_uc;
  endsequence

  // No rewrite of the register between setting it and using it
  sequence s_ucast_quiet;
    !(wr_i && hit_ucast);
  endsequence

  sequence s_self_quiet;
    !(wr_i && hit_ipmc);
  endsequence

  a_ucast_enable: assert property (
    s_ucast_cfg ##1 s_ucast_quiet ##1 s_ucast_frame |=>
      dec_override_o && dec_class_o == cls_ucast)
    else $error("Unknown unicast enable not applied");

  a_ucast_filter: assert property (
    frm_valid_i && is_uc && ucast_q.en && ucast_q.map[4:1] == 4'h0
    |=> dec_drop_o && dec_ports_o == 4'h0)
    else $error("Unknown unicast zero map did not filter");

  a_map_ports: assert property (
    frm_valid_i && is_uc && ucast_q.en
    |=> dec_ports_o == $past(ucast_q.map[4:1]))
    else $error("Port map decode wrong");

  a_mcast_ip_excl: assert property (
    frm_valid_i && frm_ip_mcast_i
    |=> dec_class_o != cls_mcast)
    else $error("IP multicast took unknown multicast map");

  a_mcast_filter: assert property (
    frm_valid_i && is_mc && mcast_q.en && mcast_q.map[4:1] == 4'h0
    |=> dec_drop_o)
    else $error("Unknown multicast zero map did not filter");

  a_vid_apply: assert property (
    frm_valid_i && !frm_vid_hit_i && vid_q.en
    |=> dec_class_o == cls_vid && dec_override_o
        && dec_ports_o == $past(vid_q.map[4:1]))
    else $error("Unknown VID map not applied");

  a_vid_filter: assert property (
    frm_valid_i && !frm_vid_hit_i && vid_q.en
    && vid_q.map[4:1] == 4'h0 |=> dec_drop_o)
    else $error("Unknown VID zero map did not filter");

  a_ipmc_apply: assert property (
    frm_valid_i && is_ipmc && ipmc_q.en
    |=> dec_class_o == cls_ipmcast
        && dec_ports_o == $past(ipmc_q.map[4:1]))
    else $error("Unknown IP multicast map not applied");

  a_ipmc_filter: assert property (
    frm_valid_i && is_ipmc && ipmc_q.en
    && ipmc_q.map[4:1] == 4'h0 |=> dec_drop_o)
    else $error("Unknown IP multicast zero map did not filter");

  a_self_drop: assert property (
    s_self_on ##1 s_self_quiet ##1 s_own_frame |=> egr_drop_o && egr_done_o)
    else $error("Own address frame not dropped");

  a_self_egress: assert property (
    egr_drop_o |-> $past(egr_valid_i) && $past(self_q)
      && $past(egr_da_i) == $past(mac_w))
    else $error("Egress drop without own address match");

  a_self_off: assert property (
    egr_valid_i && !self_q |=> egr_done_o && !egr_drop_o)
    else $error("Own address frame dropped while filter off");

  a_known_class: assert property (
    frm_valid_i && frm_vid_hit_i && frm_da_hit_i
    |=> dec_valid_o && dec_class_o == cls_known && !dec_override_o)
    else $error("Known frame classed as unknown");

  a_disabled_default: assert property (
    frm_valid_i && !frm_vid_hit_i && !vid_q.en
    |=> !dec_override_o && !dec_drop_o && dec_ports_o == 4'h0)
    else $error("Disabled class still used its map");

  a_mcast_apply: assert property (
    frm_valid_i && is_mc && mcast_q.en
    |=> dec_class_o == cls_mcast && dec_override_o
        && dec_ports_o == $past(mcast_q.map[4:1]))
    else $error("Unknown multicast map not applied");

  a_ucast_off: assert property (
    frm_valid_i && is_uc && !ucast_q.en
    |=> !dec_override_o && !dec_drop_o && dec_ports_o == 4'h0)
    else $error("Disabled unicast class still used its map");

  a_ipmc_off: assert property (
    frm_valid_i && is_ipmc && !ipmc_q.en
    |=> !dec_override_o && !dec_drop_o)
    else $error("Disabled IP multicast class still used its map");

  a_vid_first: assert property (
    frm_valid_i && !frm_vid_hit_i |=> dec_class_o == cls_vid)
    else $error("VLAN miss not classed as unknown VID");

  a_self_reset: assert property (disable iff (1'b0)
    !resetn_i |=> !self_q)
    else $error("Self filter not off after reset");

  a_read_once: assert property (
    !rd_i |=> rd_data_o == 8'h00)
    else $error("Read data outside the read cycle");

endmodule : unknown_dest_forward_control
`default_nettype wire

// ---- verif/fabric_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input  wire logic   clk_i,
  output logic        frm_valid_o,
  output logic [47:0] frm_da_o,
  output logic        frm_da_hit_o,
  output logic        frm_vid_hit_o,
  output logic        frm_ip_mcast_o,
  output logic        egr_valid_o,
  output logic [47:0] egr_da_o
);
  initial begin
    {frm_valid_o, frm_da_o, frm_da_hit_o, frm_vid_hit_o, frm_ip_mcast_o} = '0;
    {egr_valid_o, egr_da_o} = '0;
  end
  // Qualifiers mean nothing after the strobe; invert them so stale values never help
  task automatic send_frame(input logic [47:0] da, input logic dh, vh, ip);
    @(posedge clk_i);
    frm_valid_o <= 1'b1;
    {frm_da_o, frm_da_hit_o, frm_vid_hit_o, frm_ip_mcast_o} <= {da, dh, vh, ip};
    @(posedge clk_i);
    frm_valid_o <= 1'b0;
    {frm_da_o, frm_da_hit_o, frm_vid_hit_o, frm_ip_mcast_o} <= ~{da, dh, vh, ip};
  endtask : send_frame
  task automatic send_egress(input logic [47:0] da);
    @(posedge clk_i);
    egr_valid_o <= 1'b1;
    egr_da_o    <= da;
    @(posedge clk_i);
    egr_valid_o <= 1'b0;
    egr_da_o    <= ~da;
  endtask : send_egress
endmodule : fabric_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwd_ctrl_cfg.svh"
module testbench;
  import fwd_ctrl_pkg::*;
  logic        clk_i, resetn_i, wr_i, rd_i;
  logic [7:0]  addr_i, wr_data_i, rd_data_o;
  wire logic   fv, fdh, fvh, fip, ev;
  wire logic [47:0] fda, eda;
  logic        dec_valid_o, dec_override_o, dec_drop_o, egr_done_o, egr_drop_o;
  class_type   dec_class_o;
  logic [3:0]  dec_ports_o;
  logic [1:0]  drive_sel_o;
  int          n_errors = 0;
  int          cmp_count = 0;

  unknown_dest_forward_control i_unknown_dest_forward_control (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .frm_valid_i(fv),
    .frm_da_i(fda), .frm_da_hit_i(fdh), .frm_vid_hit_i(fvh), .frm_ip_mcast_i(fip),
    .dec_valid_o(dec_valid_o), .dec_class_o(dec_class_o),
    .dec_override_o(dec_override_o), .dec_drop_o(dec_drop_o),
    .dec_ports_o(dec_ports_o), .egr_valid_i(ev), .egr_da_i(eda),
    .egr_done_o(egr_done_o), .egr_drop_o(egr_drop_o), .drive_sel_o(drive_sel_o));
  fabric_model i_fabric_model (
    .clk_i(clk_i), .frm_valid_o(fv), .frm_da_o(fda), .frm_da_hit_o(fdh),
    .frm_vid_hit_o(fvh), .frm_ip_mcast_o(fip), .egr_valid_o(ev), .egr_da_o(eda));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr_i, wr_data_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  // Read data stands one cycle only, so both cycles are looked at
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, exp);
    @(posedge clk_i);
    #1 chk(rd_data_o, 8'h00);
  endtask : rd_reg
  task automatic dec(input logic [47:0] da, input logic [2:0] f, input class_type c,
                     input logic ov, dr, input logic [3:0] p);
    i_fabric_model.send_frame(da, f[2], f[1], f[0]);
    #1 chk({7'h00, dec_valid_o}, 8'h01);
    chk({5'h00, dec_class_o}, {5'h00, c});
    chk({2'h0, dec_override_o, dec_drop_o, dec_ports_o}, {2'h0, ov, dr, p});
    @(posedge clk_i);
    #1 chk({7'h00, dec_valid_o}, 8'h00);
  endtask : dec
  task automatic egr(input logic [47:0] da, input logic dr);
    i_fabric_model.send_egress(da);
    #1 chk({6'h00, egr_done_o, egr_drop_o}, {6'h00, 1'b1, dr});
    @(posedge clk_i);
    #1 chk({6'h00, egr_done_o, egr_drop_o}, 8'h00);
  endtask : egr
  task automatic wrap_up;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic check_reset;
    rd_reg(`OFS_UCAST, 8'h00);
    rd_reg(`OFS_MCAST, 8'h40);
    rd_reg(`OFS_VID, 8'h00);
    rd_reg(`OFS_IPMC, 8'h00);
    rd_reg(`OFS_MAC_LAST, 8'h00);
    chk({6'h00, drive_sel_o}, 8'h01);
  endtask : check_reset
  task automatic reg_access;
    for (int i = 8'h83; i <= 8'h87; i++) wr_reg(8'(i), 8'hFF);
    rd_reg(`OFS_UCAST, 8'h3F);
    rd_reg(`OFS_MCAST, 8'hFF);
    rd_reg(`OFS_VID, 8'h3F);
    rd_reg(`OFS_IPMC, 8'h7F);
    rd_reg(8'h87, 8'h00);
    chk({6'h00, drive_sel_o}, 8'h03);
    for (int i = 8'h83; i <= 8'h86; i++) wr_reg(8'(i), 8'h00);
  endtask : reg_access
  // Each class gets every map kind, then its enable cleared with a live map
  task automatic frames;
    logic [7:0]  ofs [4] = '{`OFS_UCAST, `OFS_MCAST, `OFS_IPMC, `OFS_VID};
    class_type   cl [4]  = '{cls_ucast, cls_mcast, cls_ipmcast, cls_vid};
    logic [2:0]  fl [4]  = '{3'b010, 3'b010, 3'b011, 3'b100};
    logic [47:0] da [4]  = '{48'h0000_1122_3344, 48'h0100_5E00_0001,
                             48'h0100_5E00_0001, 48'h0000_1122_3344};
    logic [4:0]  mp [7]  = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h07, 5'h16, 5'h1F};
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 7; m++) begin
        wr_reg(ofs[k], {3'b001, mp[m]});
        dec(da[k], fl[k], cl[k], 1'b1, mp[m][4:1] == 4'h0, mp[m][4:1]);
      end
      wr_reg(ofs[k], 8'h1E);
      dec(da[k], fl[k], cl[k], 1'b0, 1'b0, 4'h0);
      wr_reg(ofs[k], 8'h00);
    end
    wr_reg(`OFS_MCAST, 8'h3E);
    dec(da[2], fl[2], cls_ipmcast, 1'b0, 1'b0, 4'h0);
    wr_reg(`OFS_UCAST, 8'h26);
    dec(da[0], 3'b110, cls_known, 1'b0, 1'b0, 4'h0);
    dec(da[0], fl[0], cls_ucast, 1'b1, 1'b0, 4'h3);
  endtask : frames
  task automatic self_filter;
    logic [47:0] mac = 48'h0122_3344_5566;
    for (int i = 0; i < 6; i++) wr_reg(8'(`OFS_MAC_FIRST + i), mac[47 - 8 * i -: 8]);
    rd_reg(`OFS_MAC_FIRST, 8'h01);
    egr(mac, 1'b0);
    wr_reg(`OFS_IPMC, 8'h40);
    egr(mac, 1'b1);
    egr(mac ^ 48'h1, 1'b0);
    egr(mac ^ 48'h8000_0000_0000, 1'b0);
    wr_reg(8'h6B, 8'h00);
    egr({mac[47:24], 8'h00, mac[15:0]}, 1'b1);
  endtask : self_filter
  // A reset in mid-run must bring every register and decision back
  task automatic mid_reset;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 chk({5'h00, dec_class_o}, {5'h00, cls_known});
    chk({2'h0, dec_override_o, dec_drop_o, dec_ports_o}, 8'h00);
    rd_reg(`OFS_IPMC, 8'h00);
    rd_reg(`OFS_UCAST, 8'h00);
    rd_reg(`OFS_MAC_FIRST, 8'h00);
    egr(48'h0, 1'b0);
  endtask : mid_reset

  initial begin
    {resetn_i, wr_i, rd_i, addr_i, wr_data_i} = '0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    check_reset();
    reg_access();
    frames();
    self_filter();
    mid_reset();
    wrap_up();
  end
  // Hang guard: the whole run needs far fewer cycles than this
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
